// ---- fec_dev.sv ----
// flash-side embedded algorithm controller: command decode, program
// suspend/resume, blank check, erase status evaluation, chip/sector erase
// assumes host keeps its own duties; array is modelled by per-sector flags
`include "fec_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - suspend halts programming after suspend latency
// - suspend command address is ignored
// - reads served outside suspended line only
// - program suspend accepts only listed commands
// - resume restarts; repeats ignored; re-suspend allowed
// - host spaces resume and next suspend
// - no suspend in overlay; no overlay while suspended
// - blank check 33h at 555h, standby only
// - blank check not while busy or suspended
// - array reads undefined during blank check
// - bit7 ready; bit5 set when not blank
// - blank check stops early, returns to standby
// - erase check sets sector ok bit
// - erase check takes fixed time, then ready
// - chip erase six-write sequence launches erase
// - preprogram zeros then erase; erased reads FFFFh
// - chip erase honours only status reads
// - reset aborts erase, ready after recovery
// - chip erase skips protected sectors silently
// - sector erase six writes, sector address last
// - sector erase honours only status reads
// - erase of locked sector aborts with status
module fec_dev #(
	parameter int AW = 16,
	parameter int SW = 3,
	parameter int PSL_CYC = `FEC_CEIL(`FEC_PROGRAM_SUSPEND_LATENCY_NS),
	parameter int EES_CYC = `FEC_CEIL(`FEC_ERASE_CHECK_DURATION_NS),
	parameter int RPH_CYC = `FEC_CEIL(`FEC_RESET_RECOVERY_TIME_NS),
	parameter int PROG_CYC = `FEC_CEIL(`FEC_T_PROG_NS),
	parameter int ERPH_CYC = `FEC_CEIL(`FEC_T_ERPH_NS),
	parameter int BLANK_CYC = `FEC_CEIL(`FEC_T_BLANK_NS)
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	fec_if.dev bus,
	input wire logic [(1<<SW)-1:0] prot_i,
	output logic busy_o,
	output logic [7:0] status_o
);
	typedef enum logic [3:0] {
		FEC_RECOVER, FEC_IDLE, FEC_PROG, FEC_PSL, FEC_PSUSP,
		FEC_BLANK, FEC_EES, FEC_CHIP, FEC_SECT
	} fec_state_t;
	typedef enum logic [2:0] {
		FEC_SQ_NONE, FEC_SQ_U1, FEC_SQ_U2, FEC_SQ_DATA, FEC_SQ_SETUP, FEC_SQ_U3, FEC_SQ_U4
	} fec_seq_t;
	localparam int NS = 1 << SW;

	fec_state_t st_q;
	fec_seq_t seq_q;
	logic [15:0] cnt_q;
	logic [SW-1:0] sec_q;
	logic [AW-1:0] line_q;
	logic [15:0] hold_q;
	logic phase_q;
	logic aso_q;
	logic srd_q;
	logic [7:0] sr_q;
	logic [NS-1:0] blank_q;
	logic [NS-1:0] ok_q;
	logic [15:0] rdata_q;
	logic rvalid_q;
	logic busy_q;

	// command decode helpers
	function automatic logic is_cmd(input logic [15:0] d, input logic [7:0] c);
		is_cmd = (d[7:0] == c);
	endfunction
	function automatic logic at(input logic [AW-1:0] a, input logic [11:0] o);
		at = (a[11:0] == o);
	endfunction
	function automatic logic [15:0] c16(input int v);
		c16 = 16'(v);
	endfunction

	logic [SW-1:0] wsec;
	logic wr;
	logic cnt_end;
	assign wsec = bus.addr[AW-1 -: SW];
	assign wr = bus.wr & en_i;
	assign cnt_end = (cnt_q == 16'h0000);

	// ----------------------------------------
	// embedded algorithm controller state
	// ----------------------------------------
	// a hardware reset drops any operation; recovery holds busy before standby
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= FEC_RECOVER;
			seq_q <= FEC_SQ_NONE;
			cnt_q <= 16'h0000;
			sec_q <= '0;
			line_q <= '0;
			hold_q <= 16'h0000;
			phase_q <= 1'b0;
			aso_q <= 1'b0;
			sr_q <= `FEC_RST_SR;
			blank_q <= '1;
			ok_q <= '1;
		end else if (en_i) begin
			if (!cnt_end && st_q != FEC_PSUSP) begin
				cnt_q <= cnt_q - 16'h0001;
			end
			unique case (st_q)
				FEC_RECOVER: begin
					if (cnt_q == 16'h0000 && !phase_q) begin
						cnt_q <= c16(RPH_CYC - 1);
						phase_q <= 1'b1;
					end else if (cnt_end) begin
						phase_q <= 1'b0;
						st_q <= FEC_IDLE;
					end
				end
				FEC_IDLE: begin
					if (wr) begin
						seq_q <= FEC_SQ_NONE;
						if (seq_q == FEC_SQ_DATA) begin
							st_q <= FEC_PROG;
							sec_q <= wsec;
							line_q <= bus.addr;
							cnt_q <= c16(PROG_CYC - 1);
							sr_q[`FEC_SR_PROG_FAIL] <= 1'b0;
						end else if (is_cmd(bus.wdata, `FEC_DAT_UNLOCK1) &&
								at(bus.addr, `FEC_ADR_UNLOCK1) &&
								(seq_q == FEC_SQ_NONE || seq_q == FEC_SQ_SETUP)) begin
							seq_q <= (seq_q == FEC_SQ_NONE) ? FEC_SQ_U1 : FEC_SQ_U3;
						end else if (is_cmd(bus.wdata, `FEC_DAT_UNLOCK2) &&
								at(bus.addr, `FEC_ADR_UNLOCK2) &&
								(seq_q == FEC_SQ_U1 || seq_q == FEC_SQ_U3)) begin
							seq_q <= (seq_q == FEC_SQ_U1) ? FEC_SQ_U2 : FEC_SQ_U4;
						end else if (seq_q == FEC_SQ_U2 && is_cmd(bus.wdata, `FEC_CMD_PROG)) begin
							seq_q <= FEC_SQ_DATA;
						end else if (seq_q == FEC_SQ_U2 && is_cmd(bus.wdata, `FEC_CMD_SETUP)) begin
							seq_q <= FEC_SQ_SETUP;
						end else if (seq_q == FEC_SQ_U4 && is_cmd(bus.wdata, `FEC_CMD_CHIP) &&
								at(bus.addr, `FEC_ADR_UNLOCK1)) begin
							st_q <= FEC_CHIP;
							sec_q <= '0;
							phase_q <= 1'b0;
							cnt_q <= c16(ERPH_CYC - 1);
							sr_q[`FEC_SR_ERASE_FAIL] <= 1'b0;
						end else if (seq_q == FEC_SQ_U4 && is_cmd(bus.wdata, `FEC_CMD_SECT)) begin
							sec_q <= wsec;
							if (prot_i[wsec]) begin
								sr_q[`FEC_SR_ERASE_FAIL] <= 1'b1;
								sr_q[`FEC_SR_LOCK] <= 1'b1;
							end else begin
								st_q <= FEC_SECT;
								phase_q <= 1'b0;
								cnt_q <= c16(ERPH_CYC - 1);
								sr_q[`FEC_SR_ERASE_FAIL] <= 1'b0;
								sr_q[`FEC_SR_LOCK] <= 1'b0;
							end
						end else if (seq_q == FEC_SQ_NONE && !aso_q && at(bus.addr, `FEC_ADR_UNLOCK1) &&
								is_cmd(bus.wdata, `FEC_CMD_BLANK)) begin
							st_q <= FEC_BLANK;
							sec_q <= wsec;
							cnt_q <= c16(BLANK_CYC - 1);
						end else if (seq_q == FEC_SQ_NONE && at(bus.addr, `FEC_ADR_UNLOCK1) &&
								is_cmd(bus.wdata, `FEC_CMD_EES)) begin
							st_q <= FEC_EES;
							sec_q <= wsec;
							cnt_q <= c16(EES_CYC - 1);
						end else if (is_cmd(bus.wdata, `FEC_CMD_ASO_IN)) begin
							aso_q <= 1'b1;
						end else if (is_cmd(bus.wdata, `FEC_CMD_EXIT)) begin
							aso_q <= 1'b0;
						end
					end
				end
				FEC_PROG: begin
					if (cnt_end) begin
						st_q <= FEC_IDLE;
						blank_q[sec_q] <= 1'b0;
					end else if (wr && !aso_q && is_cmd(bus.wdata, `FEC_CMD_PSUSP)) begin
						st_q <= FEC_PSL;
						phase_q <= 1'b0;
					end
				end
				FEC_PSL: begin
					// the program timer keeps its value; latency runs on a second pass
					if (!phase_q) begin
						phase_q <= 1'b1;
						hold_q <= cnt_q; // keeps the remaining program count for resume
						cnt_q <= c16(PSL_CYC - 1);
					end else if (cnt_end) begin
						st_q <= FEC_PSUSP;
						sr_q[`FEC_SR_PSUSP] <= 1'b1;
						cnt_q <= hold_q;
						phase_q <= 1'b0;
					end
				end
				FEC_PSUSP: begin
					if (wr && is_cmd(bus.wdata, `FEC_CMD_PRES)) begin
						st_q <= FEC_PROG;
						sr_q[`FEC_SR_PSUSP] <= 1'b0;
					end else if (wr && is_cmd(bus.wdata, `FEC_CMD_EXIT)) begin
						aso_q <= 1'b0;
					end
				end
				FEC_BLANK: begin
					if (!blank_q[sec_q] || cnt_end) begin
						sr_q[`FEC_SR_ERASE_FAIL] <= !blank_q[sec_q];
						st_q <= FEC_IDLE;
					end
				end
				FEC_EES: begin
					if (cnt_end) begin
						sr_q[`FEC_SR_SECT_OK] <= ok_q[sec_q];
						st_q <= FEC_IDLE;
					end
				end
				FEC_CHIP: begin
					// protected sectors are passed over without touching status
					if (prot_i[sec_q] || (cnt_end && phase_q)) begin
						if (!prot_i[sec_q]) begin
							blank_q[sec_q] <= 1'b1;
							ok_q[sec_q] <= 1'b1;
						end
						phase_q <= 1'b0;
						cnt_q <= c16(ERPH_CYC - 1);
						sec_q <= sec_q + 1'b1;
						if (sec_q == SW'(NS - 1)) begin
							st_q <= FEC_IDLE;
						end
					end else if (cnt_end) begin
						phase_q <= 1'b1;
						ok_q[sec_q] <= 1'b0;
						cnt_q <= c16(ERPH_CYC - 1);
					end
				end
				FEC_SECT: begin
					if (cnt_end && phase_q) begin
						blank_q[sec_q] <= 1'b1;
						ok_q[sec_q] <= 1'b1;
						st_q <= FEC_IDLE;
					end else if (cnt_end) begin
						phase_q <= 1'b1;
						ok_q[sec_q] <= 1'b0;
						cnt_q <= c16(ERPH_CYC - 1);
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// status read mode and read answers
	// ----------------------------------------
	// a 70h write is honoured in every state; other writes in busy states are dropped, except a suspend while programming
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			srd_q <= 1'b0;
		end else if (en_i) begin
			if (wr && is_cmd(bus.wdata, `FEC_CMD_STATUS)) begin
				srd_q <= 1'b1;
			end else if (bus.rd) begin
				srd_q <= 1'b0;
			end
		end
	end

	logic ready;
	logic in_line;
	assign ready = (st_q == FEC_IDLE) || (st_q == FEC_PSUSP);
	assign in_line = (bus.addr[AW-1:`FEC_LINE_LSB] == line_q[AW-1:`FEC_LINE_LSB]);

	// busy states give junk; a suspended line gives junk too
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= `FEC_JUNK;
			rvalid_q <= 1'b0;
		end else if (en_i) begin
			rvalid_q <= bus.rd;
			if (bus.rd) begin
				if (srd_q) begin
					rdata_q <= {8'h00, ready, sr_q[6:0]};
				end else if (!ready || (st_q == FEC_PSUSP && in_line)) begin
					rdata_q <= `FEC_JUNK;
				end else begin
					rdata_q <= blank_q[wsec] ? `FEC_ERASED : `FEC_JUNK;
				end
			end
		end
	end

	// user-side flags
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			busy_q <= 1'b1;
			status_o <= `FEC_RST_SR;
		end else if (en_i) begin
			busy_q <= !ready;
			status_o <= {ready, sr_q[6:0]};
		end
	end

	assign busy_o = busy_q;
	assign bus.rdata = rdata_q;
	assign bus.rvalid = rvalid_q;
endmodule
`default_nettype wire

// ---- fec_defs.svh ----
// constants for the flash embedded-operation controller and its host
// assumes word addressing, one command write per bus write cycle
`ifndef FEC_DEFS_SVH
`define FEC_DEFS_SVH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define FEC_MCLK_NS 4
`define FEC_PROGRAM_SUSPEND_LATENCY_NS 400
`define FEC_RESUME_TO_SUSPEND_INTERVAL_NS 400
`define FEC_ERASE_CHECK_DURATION_NS 2000
`define FEC_RESET_RECOVERY_TIME_NS 400
`define FEC_T_PROG_NS 4000
`define FEC_T_ERPH_NS 2000
`define FEC_T_BLANK_NS 1000
`define FEC_CEIL(ns) (((ns) + `FEC_MCLK_NS - 1) / `FEC_MCLK_NS)

// ----------------------------------------
// command addresses and codes
// ----------------------------------------
`define FEC_ADR_UNLOCK1 12'h0555
`define FEC_ADR_UNLOCK2 12'h02AA
`define FEC_DAT_UNLOCK1 8'hAA
`define FEC_DAT_UNLOCK2 8'h55
`define FEC_CMD_PROG 8'hA0
`define FEC_CMD_SETUP 8'h80
`define FEC_CMD_CHIP 8'h10
`define FEC_CMD_SECT 8'h30
`define FEC_CMD_BLANK 8'h33
`define FEC_CMD_EES 8'hD0
`define FEC_CMD_STATUS 8'h70
`define FEC_CMD_PSUSP 8'h51
`define FEC_CMD_PRES 8'h50
`define FEC_CMD_ESUSP 8'hB0
`define FEC_CMD_ASO_IN 8'h40
`define FEC_CMD_EXIT 8'hF0
`define FEC_CMD_ICR 8'h36
`define FEC_CMD_ISR 8'h38

// ----------------------------------------
// status bits and data patterns
// ----------------------------------------
`define FEC_SR_READY 7
`define FEC_SR_ERASE_FAIL 5
`define FEC_SR_PROG_FAIL 4
`define FEC_SR_PSUSP 2
`define FEC_SR_LOCK 1
`define FEC_SR_SECT_OK 0
`define FEC_ERASED 16'hFFFF
`define FEC_JUNK 16'h0000
`define FEC_RST_SR 8'h00
`define FEC_LINE_LSB 8
`endif

// ---- fec_pkg.sv ----
// types used by the host end of the flash command link
// assumes fec_defs.svh is compiled alongside
package fec_pkg;
	typedef enum logic [2:0] {
		FEC_OP_PROG,
		FEC_OP_CHIP,
		FEC_OP_SECT,
		FEC_OP_BLANK,
		FEC_OP_EES,
		FEC_OP_PSUSP,
		FEC_OP_PRES,
		FEC_OP_STATUS
	} fec_op_t;
endpackage

// ---- fec_if.sv ----
// command-write / read link between host controller and flash controller
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface fec_if #(parameter int AW = 16);
	logic wr;
	logic rd;
	logic [AW-1:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic rvalid;
	modport dev (input wr, input rd, input addr, input wdata, output rdata, output rvalid);
	modport host (output wr, output rd, output addr, output wdata, input rdata, input rvalid);
endinterface
`default_nettype wire

// ---- fec_host.sv ----
// host-side command sequencer: expands user operations into flash
// command writes and status polls over the shared link
// assumes the flash end answers reads one cycle later
`include "fec_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fec_host #(
	parameter int AW = 16,
	parameter int PRS_CYC = `FEC_CEIL(`FEC_RESUME_TO_SUSPEND_INTERVAL_NS)
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic en_i,
	fec_if.host bus,
	input wire logic op_valid_i,
	input wire fec_pkg::fec_op_t op_i,
	input wire logic [AW-1:0] op_addr_i,
	input wire logic [15:0] op_data_i,
	output logic op_ready_o,
	output logic op_err_o,
	output logic status_valid_o,
	output logic [7:0] status_o
);
	typedef enum logic [1:0] {FEC_H_IDLE, FEC_H_SEND, FEC_H_READ, FEC_H_WAIT} fec_hst_t;

	fec_hst_t st_q;
	fec_pkg::fec_op_t op_q;
	logic [AW-1:0] a_q;
	logic [15:0] d_q;
	logic [2:0] idx_q;
	logic [15:0] prs_q;
	logic susp_q;
	logic ready_q;
	logic wr_q;
	logic rd_q;
	logic [AW-1:0] addr_q;
	logic [15:0] wdata_q;

	// number of writes an operation needs
	function automatic logic [2:0] seq_len(input fec_pkg::fec_op_t op);
		unique case (op)
			fec_pkg::FEC_OP_PROG: seq_len = 3'd4;
			fec_pkg::FEC_OP_CHIP, fec_pkg::FEC_OP_SECT: seq_len = 3'd6;
			default: seq_len = 3'd1;
		endcase
	endfunction

	// i-th write of an operation, as {address, data}
	function automatic logic [AW+15:0] seq_word(input fec_pkg::fec_op_t op, input logic [2:0] i,
			input logic [AW-1:0] a, input logic [15:0] d);
		logic [AW-1:0] u1;
		logic [AW-1:0] u2;
		logic [AW-1:0] s1;
		u1 = AW'(`FEC_ADR_UNLOCK1);
		u2 = AW'(`FEC_ADR_UNLOCK2);
		s1 = {a[AW-1:12], `FEC_ADR_UNLOCK1};
		seq_word = {u1, 8'h00, `FEC_CMD_STATUS};
		if (i == 3'd0 && seq_len(op) != 3'd1) begin
			seq_word = {u1, 8'h00, `FEC_DAT_UNLOCK1};
		end else if (i == 3'd1 || i == 3'd4) begin
			seq_word = {u2, 8'h00, `FEC_DAT_UNLOCK2};
		end else if (i == 3'd3 && op != fec_pkg::FEC_OP_PROG) begin
			seq_word = {u1, 8'h00, `FEC_DAT_UNLOCK1};
		end else if (i == 3'd2) begin
			seq_word = {u1, 8'h00, (op == fec_pkg::FEC_OP_PROG) ? `FEC_CMD_PROG : `FEC_CMD_SETUP};
		end else if (op == fec_pkg::FEC_OP_PROG) begin
			seq_word = {a, d};
		end else if (op == fec_pkg::FEC_OP_CHIP) begin
			seq_word = {u1, 8'h00, `FEC_CMD_CHIP};
		end else if (op == fec_pkg::FEC_OP_SECT) begin
			seq_word = {a, 8'h00, `FEC_CMD_SECT};
		end else if (op == fec_pkg::FEC_OP_BLANK) begin
			seq_word = {s1, 8'h00, `FEC_CMD_BLANK};
		end else if (op == fec_pkg::FEC_OP_EES) begin
			seq_word = {s1, 8'h00, `FEC_CMD_EES};
		end else if (op == fec_pkg::FEC_OP_PSUSP) begin
			seq_word = {a, 8'h00, `FEC_CMD_PSUSP};
		end else if (op == fec_pkg::FEC_OP_PRES) begin
			seq_word = {a, 8'h00, `FEC_CMD_PRES};
		end
	endfunction

	logic [AW+15:0] word;
	logic hold_susp;
	logic bad_blank;
	assign word = seq_word(op_q, idx_q, a_q, d_q);
	assign hold_susp = (op_i == fec_pkg::FEC_OP_PSUSP) && (prs_q != 16'h0000);
	assign bad_blank = (op_i == fec_pkg::FEC_OP_BLANK) && (!ready_q || susp_q);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	// a suspend waits out the resume interval so programming can advance
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= FEC_H_IDLE;
			op_q <= fec_pkg::FEC_OP_STATUS;
			a_q <= '0;
			d_q <= 16'h0000;
			idx_q <= 3'd0;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= 16'h0000;
			op_err_o <= 1'b0;
			status_valid_o <= 1'b0;
			status_o <= `FEC_RST_SR;
		end else if (en_i) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			op_err_o <= 1'b0;
			status_valid_o <= 1'b0;
			unique case (st_q)
				FEC_H_IDLE: begin
					if (op_valid_i && bad_blank) begin
						op_err_o <= 1'b1;
					end else if (op_valid_i && !hold_susp) begin
						op_q <= op_i;
						a_q <= op_addr_i;
						d_q <= op_data_i;
						idx_q <= 3'd0;
						st_q <= FEC_H_SEND;
					end
				end
				FEC_H_SEND: begin
					wr_q <= 1'b1;
					addr_q <= word[AW+15:16];
					wdata_q <= word[15:0];
					idx_q <= idx_q + 3'd1;
					if (idx_q == seq_len(op_q) - 3'd1) begin
						st_q <= (op_q == fec_pkg::FEC_OP_STATUS) ? FEC_H_READ : FEC_H_IDLE;
					end
				end
				FEC_H_READ: begin
					rd_q <= 1'b1;
					addr_q <= a_q;
					st_q <= FEC_H_WAIT;
				end
				FEC_H_WAIT: begin
					if (bus.rvalid) begin
						status_valid_o <= 1'b1;
						status_o <= bus.rdata[7:0];
						st_q <= FEC_H_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// host view of flash state
	// ----------------------------------------
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prs_q <= 16'h0000;
			susp_q <= 1'b0;
			ready_q <= 1'b0;
		end else if (en_i) begin
			if (st_q == FEC_H_SEND && op_q == fec_pkg::FEC_OP_PRES) begin
				prs_q <= 16'(PRS_CYC);
				susp_q <= 1'b0;
			end else if (prs_q != 16'h0000) begin
				prs_q <= prs_q - 16'h0001;
			end
			if (st_q == FEC_H_SEND && op_q == fec_pkg::FEC_OP_PSUSP) begin
				susp_q <= 1'b1;
			end
			if (st_q == FEC_H_SEND && op_q != fec_pkg::FEC_OP_STATUS &&
					op_q != fec_pkg::FEC_OP_PSUSP && op_q != fec_pkg::FEC_OP_PRES) begin
				ready_q <= 1'b0;
			end else if (st_q == FEC_H_WAIT && bus.rvalid) begin
				ready_q <= bus.rdata[`FEC_SR_READY];
			end
		end
	end

	assign op_ready_o = (st_q == FEC_H_IDLE) && !hold_susp;
	assign bus.wr = wr_q;
	assign bus.rd = rd_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
endmodule
`default_nettype wire

// ---- fec_link_properties.sv ----
// link checker: watches the command/read link joining host and flash ends
// assumes one clock, async active-low reset, placed beside the link
`include "fec_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module fec_link_properties #(
	parameter int AW = 16,
	parameter int PRS_CYC = 4
) (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic wr,
	input wire logic rd,
	input wire logic [AW-1:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic rvalid
);
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic [9:0] gap_q;
	logic stat_wr;
	// status-mode write; a helper so that past() sees one signal
	assign stat_wr = wr && (wdata[7:0] == `FEC_CMD_STATUS);
	// cycles since last resume; saturates so an old resume never wraps back to small
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gap_q <= 10'h3FF;
		end else if (wr && (wdata[7:0] == `FEC_CMD_PRES)) begin
			gap_q <= 10'h000;
		end else if (gap_q != 10'h3FF) begin
			gap_q <= gap_q + 10'h001;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_pair(logic [11:0] a, logic [7:0] d);
		wr && (addr[11:0] == a) && (wdata[7:0] == d);
	endsequence
	sequence s_erase_prefix;
		s_pair(`FEC_ADR_UNLOCK1, `FEC_DAT_UNLOCK1) ##1 s_pair(`FEC_ADR_UNLOCK2, `FEC_DAT_UNLOCK2)
		##1 s_pair(`FEC_ADR_UNLOCK1, `FEC_CMD_SETUP) ##1 s_pair(`FEC_ADR_UNLOCK1, `FEC_DAT_UNLOCK1)
		##1 s_pair(`FEC_ADR_UNLOCK2, `FEC_DAT_UNLOCK2);
	endsequence
	sequence s_status_rd;
		stat_wr ##1 rd;
	endsequence
	property p_status_answer;
		s_status_rd |=> rvalid;
	endproperty
	property p_rvalid_cause;
		rvalid |-> $past(rd);
	endproperty
	property p_rvalid_pulse;
		rvalid |=> !rvalid;
	endproperty
	property p_rdata_hold;
		!rvalid |-> $stable(rdata);
	endproperty
	property p_no_clash;
		!(wr && rd);
	endproperty
	property p_rd_after_status;
		rd |-> $past(stat_wr);
	endproperty
	property p_erase_cmd;
		s_erase_prefix |=> wr && (((wdata[7:0] == `FEC_CMD_CHIP)
			&& (addr[11:0] == `FEC_ADR_UNLOCK1)) || (wdata[7:0] == `FEC_CMD_SECT));
	endproperty
	property p_suspend_gap;
		(wr && (wdata[7:0] == `FEC_CMD_PSUSP)) |-> (gap_q >= PRS_CYC - 1);
	endproperty
	a_status_answer: assert property (p_status_answer) else $error("status read unanswered");
	a_rvalid_cause: assert property (p_rvalid_cause) else $error("answer without read");
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("answer longer than one cycle");
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without answer");
	a_no_clash: assert property (p_no_clash) else $error("write and read together");
	a_rd_after_status: assert property (p_rd_after_status) else $error("read not after status");
	a_erase_cmd: assert property (p_erase_cmd) else $error("erase chain ends badly");
	a_suspend_gap: assert property (p_suspend_gap) else $error("suspend too soon");
endmodule
`default_nettype wire

// ---- flash_embedded_op_controller_tb_top.sv ----
// top testbench: host and flash ends joined by the link, driven from the host's user side
// assumes short count parameters so that every operation ends within a few hundred cycles
`timescale 1ns/1ps
`default_nettype none
module flash_embedded_op_controller_tb_top;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic en_i = 1'b1;
	logic [7:0] prot_i = 8'h00;
	logic op_valid_i = 1'b0;
	fec_pkg::fec_op_t op_i = fec_pkg::FEC_OP_STATUS;
	logic [15:0] op_addr_i = 16'h0000;
	logic [15:0] op_data_i = 16'h0000;
	logic op_ready_o, op_err_o, status_valid_o, busy_o;
	logic [7:0] status_o, dev_sr, last_sr;
	int err_total = 0;
	int tests_run = 0;
	int sv_cnt = 0;
	int err_cnt = 0;
	int e;
	// ----------------------------------------
	// link, both ends and checker
	// ----------------------------------------
	fec_if fec_if_inst ();
	fec_dev #(.PSL_CYC(4), .EES_CYC(8), .PROG_CYC(40), .ERPH_CYC(8)) fec_dev_inst (
		.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.en_i(en_i), .bus(fec_if_inst.dev), .prot_i(prot_i), .busy_o(busy_o), .status_o(dev_sr));
	fec_host #(.PRS_CYC(4)) fec_host_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
		.en_i(en_i), .bus(fec_if_inst.host), .op_valid_i(op_valid_i), .op_i(op_i),
		.op_addr_i(op_addr_i), .op_data_i(op_data_i), .op_ready_o(op_ready_o),
		.op_err_o(op_err_o), .status_valid_o(status_valid_o), .status_o(status_o));
	fec_link_properties fec_link_properties_inst (.mclk_i(mclk_i),
		.rst_b_i(rst_b_i), .wr(fec_if_inst.wr), .rd(fec_if_inst.rd), .addr(fec_if_inst.addr),
		.wdata(fec_if_inst.wdata), .rdata(fec_if_inst.rdata), .rvalid(fec_if_inst.rvalid));
	// 250 MHz clock
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	// catch one-cycle pulses mid-cycle, where they are settled
	always @(negedge mclk_i) begin
		if (status_valid_o === 1'b1) begin
			last_sr = status_o;
			sv_cnt++;
		end
		if (op_err_o === 1'b1) begin
			err_cnt++;
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic stuck(input string name);
		err_total++;
		$display("wrong value %s expected done seen timeout", name);
		wrap_up();
	endtask
	task automatic chk(input string name, input logic [7:0] m, input logic [7:0] x,
		input logic [7:0] got);
		tests_run++;
		if ((got & m) !== x) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, x, got & m);
		end
	endtask
	// request held from a falling edge until a rising edge sees ready
	task automatic do_op(input fec_pkg::fec_op_t op, input logic [15:0] a, input logic [15:0] d);
		int i;
		@(negedge mclk_i);
		op_i = op;
		op_addr_i = a;
		op_data_i = d;
		op_valid_i = 1'b1;
		for (i = 0; i < 300 && op_ready_o !== 1'b1; i++) begin
			@(negedge mclk_i);
		end
		if (i == 300) begin
			stuck("op_ready");
		end
		@(negedge mclk_i);
		op_valid_i = 1'b0;
	endtask
	task automatic rd_status();
		int i;
		int c;
		c = sv_cnt;
		do_op(fec_pkg::FEC_OP_STATUS, 16'h0000, 16'h0000);
		for (i = 0; i < 50 && sv_cnt == c; i++) begin
			@(negedge mclk_i);
		end
		if (i == 50) begin
			stuck("status_valid");
		end
	endtask
	// poll status; the ready bit is the only completion sign the host has
	task automatic wait_ready();
		int i;
		for (i = 0; i < 100; i++) begin
			rd_status();
			if (last_sr[7] === 1'b1) begin
				break;
			end
		end
		if (i == 100) begin
			stuck("ready");
		end
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 400 && busy_o !== 1'b0; i++) begin
			@(negedge mclk_i);
		end
		if (i == 400) begin
			stuck("busy");
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge mclk_i);
		rst_b_i = 1'b1;
		wait_idle();
		rd_status();
		chk("sr", 8'hFF, 8'h80, last_sr);
		do_op(fec_pkg::FEC_OP_EES, 16'h2555, 16'h0000);
		// a low enable must freeze the evaluation timer, so busy outlasts its length
		repeat (4) @(negedge mclk_i);
		en_i = 1'b0;
		repeat (20) @(negedge mclk_i);
		chk("busy", 8'h01, 8'h01, {7'h00, busy_o});
		en_i = 1'b1;
		wait_ready();
		chk("sr", 8'h81, 8'h81, last_sr);
		do_op(fec_pkg::FEC_OP_BLANK, 16'h4555, 16'h0000);
		wait_ready();
		chk("sr", 8'h20, 8'h00, last_sr);
		// program, suspended at an address far from the programmed word
		do_op(fec_pkg::FEC_OP_PROG, 16'h4010, 16'h1234);
		do_op(fec_pkg::FEC_OP_PSUSP, 16'hFFFF, 16'h0000);
		wait_ready();
		chk("sr", 8'h84, 8'h84, last_sr);
		chk("dev_sr", 8'h04, 8'h04, dev_sr);
		e = err_cnt;
		do_op(fec_pkg::FEC_OP_BLANK, 16'h2555, 16'h0000);
		repeat (4) @(negedge mclk_i);
		chk("op_err", 8'hFF, 8'h01, 8'(err_cnt - e));
		do_op(fec_pkg::FEC_OP_CHIP, 16'h0000, 16'h0000);
		rd_status();
		chk("sr", 8'h84, 8'h84, last_sr);
		do_op(fec_pkg::FEC_OP_PRES, 16'h0000, 16'h0000);
		do_op(fec_pkg::FEC_OP_PRES, 16'h0000, 16'h0000);
		rd_status();
		chk("sr", 8'h84, 8'h00, last_sr);
		do_op(fec_pkg::FEC_OP_PSUSP, 16'h0000, 16'h0000);
		wait_ready();
		chk("sr", 8'h84, 8'h84, last_sr);
		do_op(fec_pkg::FEC_OP_PRES, 16'h0000, 16'h0000);
		wait_ready();
		chk("sr", 8'h84, 8'h80, last_sr);
		// a written sector fails blank check at once
		do_op(fec_pkg::FEC_OP_BLANK, 16'h4555, 16'h0000);
		rd_status();
		chk("sr", 8'hA0, 8'hA0, last_sr);
		// chip erase with one protected sector; a stray suspend must be dropped
		prot_i = 8'h08;
		do_op(fec_pkg::FEC_OP_CHIP, 16'h0000, 16'h0000);
		do_op(fec_pkg::FEC_OP_PSUSP, 16'h0000, 16'h0000);
		rd_status();
		chk("sr", 8'h84, 8'h00, last_sr);
		wait_ready();
		chk("sr", 8'h22, 8'h00, last_sr);
		do_op(fec_pkg::FEC_OP_BLANK, 16'h4555, 16'h0000);
		wait_ready();
		chk("sr", 8'h20, 8'h00, last_sr);
		// hardware reset in mid erase
		do_op(fec_pkg::FEC_OP_SECT, 16'h4000, 16'h0000);
		repeat (10) @(negedge mclk_i);
		rst_b_i = 1'b0;
		@(negedge mclk_i);
		chk("busy", 8'h01, 8'h01, {7'h00, busy_o});
		repeat (2) @(negedge mclk_i);
		rst_b_i = 1'b1;
		@(negedge mclk_i);
		chk("busy", 8'h01, 8'h01, {7'h00, busy_o});
		wait_idle();
		rd_status();
		chk("sr", 8'hFF, 8'h80, last_sr);
		do_op(fec_pkg::FEC_OP_SECT, 16'h6000, 16'h0000);
		wait_ready();
		chk("sr", 8'h22, 8'h22, last_sr);
		wrap_up();
	end
endmodule
`default_nettype wire
